//--- verilog/hbrs_top.sv
`timescale 1ns/100ps
// Overview of operation
// RL1: A loop latches its burnout alarm when its sensed current falls below its threshold.
// RL2: Once set the alarm stays set until the threshold is zero or the unit is reset.
// RL3: Every loop has its own threshold and is compared only against it.
// RL4: Control on all loops goes on regardless of any burnout alarm.
// RL5: Comparison only counts once the control output has been on for over 200 ms.
// RL6: The host programs active thresholds between 0.1 and 49.9 A.
// RL7: A zero threshold disables detection and keeps the alarm off.
// RL8: A threshold of 50.0 A disables detection and forces the alarm on.
// RL9: The latest sensed current of each loop is readable in a monitor word.
// RL10: No detection for position control, cycle control or three-phase loads.
// RL11: The host keeps normal and burnout currents 1.0 A or 2.5 A apart.
// RL12: A set stop bit halts a loop's control, a clear one lets it run.
// RL13: All stop bits read clear after reset so every loop starts running.
// RL14: Stop bits sit at bits 06 and 04 of each loop-pair command word.
// RL15: Control and alarm outputs stay off for about 4 s after power-up.
// RL16: With output retain the host leaves output bits set entering program mode.
// RL17: The alarm latches on the first qualifying current sample.
module hbrs_top import hbrs_pkg::*; #(
   parameter int unsigned ON_CYC = HBRS_ON_MIN_CYC,
   parameter int unsigned STARTUP_CYC = HBRS_STARTUP_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [HBRS_AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [HBRS_AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [HBRS_NLOOP*HBRS_DW-1:0] heat_cur_i,
   input wire logic [HBRS_NLOOP-1:0] heat_cur_vld_i,
   input wire logic [HBRS_NLOOP-1:0] ctrl_req_i,
   output logic [HBRS_NLOOP-1:0] ctrl_out_o,
   output logic [HBRS_NLOOP-1:0] burnout_alarm_output_o
);

   localparam logic [31:0] STUP_LAST = 32'(STARTUP_CYC - 1);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [HBRS_AW-1:0] aw_addr_q;
   logic aw_full_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_full_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [5:0] rd_idx;
   logic wr_ok;
   logic [31:0] rd_data;
   logic rd_err;
   logic [15:0] cmd01_q;
   logic [15:0] cmd23_q;
   logic [15:0] cfg_q;
   logic [15:0] thr_q [HBRS_NLOOP];
   logic [HBRS_NLOOP-1:0] stop;
   logic [HBRS_NLOOP-1:0] det_en;
   logic [HBRS_NLOOP-1:0] alarm;
   logic [15:0] mon [HBRS_NLOOP];
   logic [HBRS_NLOOP-1:0] ctrl_out_q;
   logic [HBRS_NLOOP-1:0] alarm_out_q;
   hbrs_state_t st_q;
   logic [31:0] stup_cnt_q;
   logic start_done;

   function automatic logic [15:0] hbrs_merge(
      input logic [15:0] old,
      input logic [31:0] wd,
      input logic [3:0] st
   );
      logic [15:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // AXI4-Lite write channels
   // ---------------------------------------------------------------
   // Address and data may arrive in either order; both held until used
   assign s_axi_awready_o = !aw_full_q && !bvalid_q;
   assign s_axi_wready_o = !w_full_q && !bvalid_q;
   assign wr_en = aw_full_q && w_full_q && !bvalid_q;
   assign wr_idx = aw_addr_q[7:2];

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_addr_q <= '0;
         aw_full_q <= 1'b0;
      end else if (wr_en) begin
         aw_full_q <= 1'b0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_addr_q <= s_axi_awaddr_i;
         aw_full_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         w_full_q <= 1'b0;
      end else if (wr_en) begin
         w_full_q <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_data_q <= s_axi_wdata_i;
         w_strb_q <= s_axi_wstrb_i;
         w_full_q <= 1'b1;
      end
   end

   always_comb begin
      wr_ok = 1'b1;
      if (wr_idx == HBRS_IDX_CMD01) begin
         wr_ok = 1'b1;
      end else if (wr_idx == HBRS_IDX_CMD23) begin
         wr_ok = 1'b1;
      end else if (wr_idx == HBRS_IDX_CFG) begin
         wr_ok = 1'b1;
      end else if (wr_idx == HBRS_IDX_STAT) begin
         wr_ok = 1'b1;
      end else if (wr_idx >= HBRS_IDX_THR0 && wr_idx <= HBRS_IDX_MON_LAST) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= HBRS_RESP_OKAY;
      end else if (wr_en) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? HBRS_RESP_OKAY : HBRS_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign s_axi_arready_o = !rvalid_q;
   assign rd_idx = s_axi_araddr_i[7:2];

   always_comb begin
      rd_data = 32'h0;
      rd_err = 1'b0;
      if (rd_idx == HBRS_IDX_CMD01) begin
         rd_data = {16'h0, cmd01_q};
      end else if (rd_idx == HBRS_IDX_CMD23) begin
         rd_data = {16'h0, cmd23_q};
      end else if (rd_idx == HBRS_IDX_CFG) begin
         rd_data = {16'h0, cfg_q};
      end else if (rd_idx == HBRS_IDX_STAT) begin
         rd_data[HBRS_NLOOP-1:0] = alarm;
         rd_data[HBRS_STAT_DONE_BIT] = start_done;
      end else if (rd_idx >= HBRS_IDX_THR0 && rd_idx <= HBRS_IDX_THR_LAST) begin
         rd_data = {16'h0, thr_q[rd_idx[1:0]]};
      end else if (rd_idx >= HBRS_IDX_MON0 && rd_idx <= HBRS_IDX_MON_LAST) begin
         rd_data = {16'h0, mon[rd_idx[1:0]]}; // RL9
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rvalid_q <= 1'b0;
         rresp_q <= HBRS_RESP_OKAY;
         rdata_q <= 32'h0;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_err ? HBRS_RESP_SLVERR : HBRS_RESP_OKAY;
         rdata_q <= rd_data;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rresp_o = rresp_q;
   assign s_axi_rdata_o = rdata_q;

   // ---------------------------------------------------------------
   // Command and configuration words
   // ---------------------------------------------------------------
   // Unused command bits read as zero
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmd01_q <= HBRS_CMD_RST; // RL13
         cmd23_q <= HBRS_CMD_RST; // RL13
      end else if (wr_en && wr_idx == HBRS_IDX_CMD01) begin
         cmd01_q <= hbrs_merge(cmd01_q, w_data_q, w_strb_q) &
                    HBRS_CMD_RW_MASK;
      end else if (wr_en && wr_idx == HBRS_IDX_CMD23) begin
         cmd23_q <= hbrs_merge(cmd23_q, w_data_q, w_strb_q) &
                    HBRS_CMD_RW_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_q <= HBRS_CFG_RST;
      end else if (wr_en && wr_idx == HBRS_IDX_CFG) begin
         cfg_q <= hbrs_merge(cfg_q, w_data_q, w_strb_q);
      end
   end

   assign stop = {cmd23_q[HBRS_STOP_B_BIT], cmd23_q[HBRS_STOP_A_BIT],
                  cmd01_q[HBRS_STOP_B_BIT], cmd01_q[HBRS_STOP_A_BIT]}; // RL14

   // ---------------------------------------------------------------
   // Power-up hold-off
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= HBRS_ST_BOOT;
         stup_cnt_q <= 32'h0;
      end else begin
         case (st_q)
            HBRS_ST_BOOT: begin
               if (stup_cnt_q == STUP_LAST) begin
                  st_q <= HBRS_ST_RUN; // RL15
               end else begin
                  stup_cnt_q <= stup_cnt_q + 32'h1;
               end
            end
            HBRS_ST_RUN: begin
               st_q <= HBRS_ST_RUN;
            end
            default: begin
               st_q <= HBRS_ST_BOOT;
            end
         endcase
      end
   end

   assign start_done = (st_q == HBRS_ST_RUN);

   // ---------------------------------------------------------------
   // Per-loop control path and burnout detectors
   // ---------------------------------------------------------------
   generate
      for (genvar g = 0; g < HBRS_NLOOP; g++) begin : g_loop
         hbrs_loop_if lp_if ();
         logic [HBRS_CFG_FW-1:0] cfg_f;
         hbrs_method_t meth;

         assign cfg_f = cfg_q[g*HBRS_CFG_FW +: HBRS_CFG_FW];
         assign meth = hbrs_method_t'(cfg_f[1:0]);
         assign det_en[g] = (meth == HBRS_M_TPROP) &&
                            !cfg_f[HBRS_CFG_3PH_BIT]; // RL10

         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               thr_q[g] <= HBRS_THR_RST;
            end else if (wr_en && wr_idx == 6'(HBRS_IDX_THR0 + g)) begin
               thr_q[g] <= hbrs_merge(thr_q[g], w_data_q, w_strb_q); // RL3
            end
         end

         // Burnout alarm never gates the control output
         always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               ctrl_out_q[g] <= 1'b0;
               alarm_out_q[g] <= 1'b0;
            end else begin
               ctrl_out_q[g] <= ctrl_req_i[g] && !stop[g] &&
                                start_done; // RL4 RL12 RL15
               alarm_out_q[g] <= alarm[g] && start_done; // RL15
            end
         end

         assign lp_if.thr = thr_q[g];
         assign lp_if.cur = heat_cur_i[g*HBRS_DW +: HBRS_DW];
         assign lp_if.cur_vld = heat_cur_vld_i[g];
         assign lp_if.ctrl_on = ctrl_out_q[g];
         assign lp_if.det_en = det_en[g];
         assign alarm[g] = lp_if.alarm;
         assign mon[g] = lp_if.mon;

         hbrs_burnout #(
            .ON_CYC(ON_CYC)
         ) u_det (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .lp(lp_if.det)
         );

         AST_STOP_HALT: assert property (@(posedge clk_i)
            disable iff (!rstn_i) stop[g] |=> !ctrl_out_q[g]) // RL12
            else $error("stopped loop still drives control");
         AST_CTRL_CONT: assert property (@(posedge clk_i)
            disable iff (!rstn_i)
            ctrl_req_i[g] && !stop[g] && start_done |=> ctrl_out_q[g]) // RL4
            else $error("running loop lost its control output");
      end
   endgenerate

   assign ctrl_out_o = ctrl_out_q;
   assign burnout_alarm_output_o = alarm_out_q;

   AST_STARTUP: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !start_done |=> (ctrl_out_q == '0) && (alarm_out_q == '0)) // RL15
      else $error("output active during power-up hold-off");
   AST_LAYOUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (cmd01_q[HBRS_STOP_B_BIT] |=> !ctrl_out_q[1]) and
      (cmd23_q[HBRS_STOP_A_BIT] |=> !ctrl_out_q[2])) // RL14
      else $error("stop bit taken from wrong position");
   AST_RUN_AT_RESET: assert property (@(posedge clk_i)
      $rose(rstn_i) |-> stop == '0) // RL13
      else $error("stop bit set out of reset");

endmodule

//--- pkg/hbrs_pkg.sv
package hbrs_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int HBRS_NLOOP = 4;
   localparam int HBRS_DW = 16;
   localparam int HBRS_AW = 8;

   // ---------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [5:0] HBRS_IDX_CMD01 = 6'h02;
   localparam logic [5:0] HBRS_IDX_CMD23 = 6'h0c;
   localparam logic [5:0] HBRS_IDX_THR0 = 6'h04;
   localparam logic [5:0] HBRS_IDX_THR_LAST = 6'h07;
   localparam logic [5:0] HBRS_IDX_MON0 = 6'h08;
   localparam logic [5:0] HBRS_IDX_MON_LAST = 6'h0b;
   localparam logic [5:0] HBRS_IDX_CFG = 6'h10;
   localparam logic [5:0] HBRS_IDX_STAT = 6'h11;

   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int HBRS_STOP_A_BIT = 6;
   localparam int HBRS_STOP_B_BIT = 4;
   localparam logic [15:0] HBRS_CMD_RW_MASK = 16'hf05f;
   localparam logic [15:0] HBRS_CMD_RST = 16'h0000;
   localparam logic [15:0] HBRS_THR_RST = 16'h0000;
   localparam logic [15:0] HBRS_CFG_RST = 16'h0000;
   localparam int HBRS_CFG_FW = 4;
   localparam int HBRS_CFG_3PH_BIT = 2;
   localparam int HBRS_STAT_DONE_BIT = 8;

   // Threshold in 0.1 A units
   localparam logic [15:0] HBRS_THR_OFF = 16'h0000;
   localparam logic [15:0] HBRS_THR_FULL = 16'h01f4;

   typedef enum logic [1:0] {
      HBRS_M_TPROP = 2'h0,
      HBRS_M_POS = 2'h1,
      HBRS_M_CYCLE = 2'h2
   } hbrs_method_t;

   typedef enum logic [1:0] {
      HBRS_ST_BOOT = 2'b01,
      HBRS_ST_RUN = 2'b10
   } hbrs_state_t;

   localparam logic [1:0] HBRS_RESP_OKAY = 2'h0;
   localparam logic [1:0] HBRS_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int HBRS_CLK_HZ = 100_000_000;
   localparam int HBRS_ON_MIN_MS = 200;
   localparam int HBRS_ON_MIN_CYC = HBRS_ON_MIN_MS * (HBRS_CLK_HZ / 1000);
   localparam int HBRS_STARTUP_S = 4;
   localparam int HBRS_STARTUP_CYC = HBRS_STARTUP_S * HBRS_CLK_HZ;

endpackage

//--- pkg/hbrs_loop_if.sv
`timescale 1ns/100ps
interface hbrs_loop_if import hbrs_pkg::*; ();
   logic [HBRS_DW-1:0] thr;
   logic [HBRS_DW-1:0] cur;
   logic cur_vld;
   logic ctrl_on;
   logic det_en;
   logic alarm;
   logic [HBRS_DW-1:0] mon;

   modport ctl (
      output thr, cur, cur_vld, ctrl_on, det_en,
      input alarm, mon
   );
   modport det (
      input thr, cur, cur_vld, ctrl_on, det_en,
      output alarm, mon
   );
endinterface

//--- verilog/hbrs_burnout.sv
`timescale 1ns/100ps
module hbrs_burnout import hbrs_pkg::*; #(
   parameter int unsigned ON_CYC = HBRS_ON_MIN_CYC
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   hbrs_loop_if.det lp
);

   localparam logic [31:0] ON_SAT = 32'(ON_CYC + 1);

   logic [31:0] on_cnt_q;
   logic on_long;
   logic thr_active;
   logic cmp_hit;
   logic alarm_q;
   logic [HBRS_DW-1:0] mon_q;

   // ---------------------------------------------------------------
   // On-time qualification
   // ---------------------------------------------------------------
   // Saturates one past the limit so that only strictly longer counts
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         on_cnt_q <= 32'h0;
      end else if (!lp.ctrl_on) begin
         on_cnt_q <= 32'h0; // RL5
      end else if (on_cnt_q != ON_SAT) begin
         on_cnt_q <= on_cnt_q + 32'h1;
      end
   end

   assign on_long = (on_cnt_q == ON_SAT); // RL5
   assign thr_active = (lp.thr != HBRS_THR_OFF) && (lp.thr < HBRS_THR_FULL);
   assign cmp_hit = on_long && lp.det_en && lp.cur_vld && thr_active &&
                    (lp.cur < lp.thr); // RL1 RL3 RL10 RL17

   // ---------------------------------------------------------------
   // Current monitor and alarm latch
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mon_q <= '0;
      end else if (lp.cur_vld) begin
         mon_q <= lp.cur; // RL9
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         alarm_q <= 1'b0; // RL2
      end else if (lp.thr == HBRS_THR_OFF) begin
         alarm_q <= 1'b0; // RL2 RL7
      end else if (lp.thr >= HBRS_THR_FULL) begin
         alarm_q <= 1'b1; // RL8
      end else if (cmp_hit) begin
         alarm_q <= 1'b1; // RL1 RL17
      end
   end

   assign lp.alarm = alarm_q;
   assign lp.mon = mon_q;

   AST_ALARM_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmp_hit |=> alarm_q) // RL1
      else $error("alarm not latched on low current");
   AST_ALARM_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      alarm_q && (lp.thr != HBRS_THR_OFF) |=> alarm_q) // RL2
      else $error("alarm latch released without zero threshold");
   AST_ZERO_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (lp.thr == HBRS_THR_OFF) |=> !alarm_q) // RL7
      else $error("alarm set while threshold is zero");
   AST_FULL_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (lp.thr == HBRS_THR_FULL) |=> alarm_q) // RL8
      else $error("alarm not forced at full threshold");
   AST_NO_EARLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !on_long && !alarm_q && thr_active |=> !alarm_q) // RL5
      else $error("alarm set before on-time qualified");
   AST_UNAVAIL: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !lp.det_en && !alarm_q && thr_active |=> !alarm_q) // RL10
      else $error("alarm set with detection unavailable");
   AST_MON: assert property (@(posedge clk_i) disable iff (!rstn_i)
      lp.cur_vld |=> mon_q == $past(lp.cur)) // RL9
      else $error("monitor word missed a sample");

endmodule

//--- tb/hbrs_heater_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Heater and sense transformer stand-in, one sample every PERIOD+1
// ---------------------------------------------------------------
module hbrs_heater_model import hbrs_pkg::*; #(
   parameter int PERIOD = 3
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [HBRS_NLOOP-1:0] ctrl_i,
   input wire logic [HBRS_NLOOP*HBRS_DW-1:0] nom_i,
   input wire logic [HBRS_NLOOP-1:0] burnt_i,
   output logic [HBRS_NLOOP*HBRS_DW-1:0] cur_o,
   output logic [HBRS_NLOOP-1:0] vld_o
);
   int cnt;
   // Current flows only while driven and intact, so an off heater reads 0
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 0;
         vld_o <= '0;
         cur_o <= '0;
      end else begin
         cnt <= (cnt == PERIOD) ? 0 : cnt + 1;
         vld_o <= {HBRS_NLOOP{cnt == PERIOD}};
         for (int k = 0; k < HBRS_NLOOP; k++) begin
            cur_o[k*HBRS_DW +: HBRS_DW] <= (ctrl_i[k] && !burnt_i[k]) ?
               nom_i[k*HBRS_DW +: HBRS_DW] : '0;
         end
      end
   end
endmodule

//--- tb/hbrs_top_bench.sv
`timescale 1ns/100ps
module hbrs_top_bench import hbrs_pkg::*;;
   logic clk_i, rstn_i, awv, wv, bready, arv, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, req, burnt, ctrl, alarm, vld;
   logic awrdy, wrdy, bvalid, arrdy, rvalid;
   logic [1:0] bresp, rresp;
   logic [63:0] nom, cur;
   logic [15:0] thr [4];
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   int n_errors, comparisons;

   hbrs_top #(.ON_CYC(10), .STARTUP_CYC(20)) dut (.clk_i(clk_i),
      .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .heat_cur_i(cur),
      .heat_cur_vld_i(vld), .ctrl_req_i(req), .ctrl_out_o(ctrl),
      .burnout_alarm_output_o(alarm));
   hbrs_heater_model u_heat (.clk_i(clk_i), .rstn_i(rstn_i), .ctrl_i(ctrl),
      .nom_i(nom), .burnt_i(burnt), .cur_o(cur), .vld_o(vld));

   initial begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic give_verdict();
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [33:0] seen,
                        input logic [33:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // ---------------------------------------------------------------
   // Bus master: ready sampled at negedge, acted on at next posedge
   // ---------------------------------------------------------------
   task automatic axi_wr(input logic [5:0] idx, input logic [15:0] d,
                         input logic [1:0] er);
      logic a, w, a_ok, w_ok;
      a = 1;
      w = 1;
      bq.push_back(er);
      @(posedge clk_i);
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0, d};
      awv <= 1;
      wv <= 1;
      bready <= 1;
      while (a || w) begin
         @(negedge clk_i);
         a_ok = a && awrdy;
         w_ok = w && wrdy;
         @(posedge clk_i);
         if (a_ok) begin
            a = 0;
            awv <= 0;
         end
         if (w_ok) begin
            w = 0;
            wv <= 0;
         end
      end
      while (!a) begin
         @(negedge clk_i);
         a = bvalid;
         @(posedge clk_i);
      end
      bready <= 0;
   endtask

   task automatic axi_rd(input logic [5:0] idx, input logic [1:0] er,
                         input logic [15:0] ed);
      logic t;
      rq.push_back({er, 16'h0, ed});
      @(posedge clk_i);
      araddr <= {idx, 2'b00};
      arv <= 1;
      rready <= 1;
      t = 0;
      while (!t) begin
         @(negedge clk_i);
         t = arrdy;
         @(posedge clk_i);
      end
      arv <= 0;
      t = 0;
      while (!t) begin
         @(negedge clk_i);
         t = rvalid;
         @(posedge clk_i);
      end
      rready <= 0;
   endtask

   // Oldest noted read result against what the bus returns
   always @(negedge clk_i) begin
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
         check("rdata", {rresp, rdata}, rq.pop_front());
   end

   // Oldest noted write response against what the bus returns
   always @(negedge clk_i) begin
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
         check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rstn_i, awv, wv, bready, arv, rready} = '0;
      {awaddr, araddr, wdata, burnt} = '0;
      wstrb = 4'hf;
      req = 4'hf;
      void'($urandom(71));
      for (int k = 0; k < 4; k++) begin
         nom[k*16 +: 16] = 16'(100 + $urandom % 300);
         thr[k] = nom[k*16 +: 16] >> 1;
      end
      repeat (6) @(posedge clk_i);
      rstn_i <= 1;
      settle(5);
      check("ctrl_boot", {30'h0, ctrl}, 34'h0);
      axi_rd(HBRS_IDX_CMD01, HBRS_RESP_OKAY, 16'h0);
      axi_rd(HBRS_IDX_CMD23, HBRS_RESP_OKAY, 16'h0);
      settle(25);
      check("ctrl_run", {30'h0, ctrl}, 34'hf);
      @(posedge clk_i);
      req <= 4'h5;
      settle(2);
      check("ctrl_req", {30'h0, ctrl}, 34'h5);
      @(posedge clk_i);
      req <= 4'hf;
      axi_wr(HBRS_IDX_CMD01, 16'h0040, HBRS_RESP_OKAY);
      settle(3);
      check("stop_a", {30'h0, ctrl}, 34'he);
      axi_wr(HBRS_IDX_CMD01, 16'h0010, HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_CMD23, 16'hffff, HBRS_RESP_OKAY);
      settle(3);
      check("stop_b", {30'h0, ctrl}, 34'h1);
      axi_rd(HBRS_IDX_CMD23, HBRS_RESP_OKAY, HBRS_CMD_RW_MASK);
      axi_wr(HBRS_IDX_CMD01, 16'h0, HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_CMD23, 16'h0, HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_THR0, thr[0], HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_THR0 + 6'h1, thr[1], HBRS_RESP_OKAY);
      settle(30);
      check("alarm_ok", {30'h0, alarm}, 34'h0);
      for (int k = 0; k < 4; k++)
         axi_rd(HBRS_IDX_MON0 + 6'(k), HBRS_RESP_OKAY, nom[k*16 +: 16]);
      burnt[0] <= 1;
      settle(15);
      check("alarm_burn", {30'h0, alarm}, 34'h1);
      check("ctrl_keep", {30'h0, ctrl}, 34'hf);
      burnt[0] <= 0;
      settle(10);
      check("alarm_latch", {30'h0, alarm}, 34'h1);
      axi_rd(HBRS_IDX_STAT, HBRS_RESP_OKAY, 16'h0101);
      burnt[0] <= 1;
      axi_wr(HBRS_IDX_THR0, HBRS_THR_OFF, HBRS_RESP_OKAY);
      settle(20);
      check("alarm_off", {30'h0, alarm}, 34'h0);
      axi_wr(HBRS_IDX_THR0 + 6'h1, HBRS_THR_FULL, HBRS_RESP_OKAY);
      settle(3);
      check("alarm_full", {30'h0, alarm}, 34'h2);
      axi_wr(HBRS_IDX_THR0 + 6'h1, HBRS_THR_OFF, HBRS_RESP_OKAY);
      // Position method on loop 2, three-phase load on loop 3
      axi_wr(HBRS_IDX_CFG, 16'h4100, HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_THR0 + 6'h2, thr[2], HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_THR_LAST, thr[3], HBRS_RESP_OKAY);
      burnt[3:2] <= 2'b11;
      settle(25);
      check("alarm_nodet", {30'h0, alarm}, 34'h0);
      // Short on-period must not count, a long one must
      axi_wr(HBRS_IDX_CMD01, 16'h0040, HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_THR0, thr[0], HBRS_RESP_OKAY);
      axi_wr(HBRS_IDX_CMD01, 16'h0, HBRS_RESP_OKAY);
      repeat (6) begin
         @(negedge clk_i);
         check("alarm_short", {33'h0, alarm[0]}, 34'h0);
      end
      settle(20);
      check("alarm_long", {30'h0, alarm}, 34'h1);
      axi_rd(6'h3f, HBRS_RESP_SLVERR, 16'h0);
      axi_wr(6'h3e, 16'h1234, HBRS_RESP_SLVERR);
      settle(4);
      give_verdict();
   end
endmodule
